// ---- verilog/dacp_pkg.sv ----
// Package of constants for the dual converter serial capture block
package dacp_pkg;
  localparam int          CLK_MHZ         = 100;
  localparam int          SCLK_MAX_MHZ    = 32;
  localparam int          CONV_NS_X10     = 4375;
  localparam int          CONV_CYC        = (CONV_NS_X10 * CLK_MHZ) / 10000;
  localparam logic [3:0]  WLEN_16         = 4'hf;
  localparam logic [3:0]  WLEN_14         = 4'hd;
  localparam logic [3:0]  WLEN_PD         = 4'h9;
  localparam logic [4:0]  PD_BURST        = 5'h08;
  localparam int          WORD_W          = 16;
  localparam logic        FS_ACTIVE_LEVEL = 1'b0;
  localparam int          DIV_W           = 16;
  localparam logic [15:0] DIV_RESET       = 16'h0001;
  localparam logic [15:0] START_RESET     = 16'h0064;
  typedef enum logic [1:0] {ST_IDLE, ST_ASSERT, ST_BURST, ST_GAP} dacp_state_t;
endpackage

// ---- verilog/dacp_rx_if.sv ----
// Interface carrying the word length and captured words between modules
interface dacp_rx_if;
  logic [3:0]  word_len;
  logic        enable;
  logic [15:0] word_a;
  logic [15:0] word_b;
  logic        word_valid;
  modport ctrl (output word_len, output enable, input word_a, input word_b, input word_valid);
  modport port (input word_len, input enable, output word_a, output word_b, output word_valid);
endinterface

// ---- verilog/dacp_serial_rx.sv ----
// Receive port: samples both converter data lines on serial clock edges
module dacp_serial_rx
  import dacp_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_sclk_rise,
  input  wire logic i_fs_n,
  input  wire logic i_data_a,
  input  wire logic i_data_b,
  dacp_rx_if.port   rx
);
  logic [15:0] sh_a_q;
  logic [15:0] sh_b_q;
  logic [4:0]  cnt_q;
  logic        busy_q;
  logic        fs_prev_q;
  logic [15:0] wa_q;
  logic [15:0] wb_q;
  logic        vld_q;

  wire logic [4:0] len       = 5'(rx.word_len) + 5'd1;
  wire logic       fs_active = (i_fs_n == FS_ACTIVE_LEVEL);
  wire logic       fs_fall   = fs_active && fs_prev_q;
  wire logic       last_bit  = busy_q && i_sclk_rise && (cnt_q == len - 5'd1);

  // One frame sync per word; external sync, active low
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sh_a_q    <= 16'h0000;
      sh_b_q    <= 16'h0000;
      cnt_q     <= 5'h00;
      busy_q    <= 1'b0;
      fs_prev_q <= 1'b1;
      wa_q      <= 16'h0000;
      wb_q      <= 16'h0000;
      vld_q     <= 1'b0;
    end else begin
      fs_prev_q <= i_fs_n;
      vld_q     <= 1'b0;
      if (!rx.enable) begin
        busy_q <= 1'b0;
      end else if (fs_fall) begin
        busy_q <= 1'b1;
        cnt_q  <= 5'h00;
        sh_a_q <= 16'h0000;
        sh_b_q <= 16'h0000;
      end else if (busy_q && i_sclk_rise) begin
        // MSB first, both lines at once
        sh_a_q <= {sh_a_q[14:0], i_data_a};
        sh_b_q <= {sh_b_q[14:0], i_data_b};
        cnt_q  <= cnt_q + 5'd1;
        if (last_bit) begin
          busy_q <= 1'b0;
          // Zero filled upper bits
          wa_q   <= {sh_a_q[14:0], i_data_a};
          wb_q   <= {sh_b_q[14:0], i_data_b};
          vld_q  <= 1'b1;
        end
      end
    end
  end

  assign rx.word_a     = wa_q;
  assign rx.word_b     = wb_q;
  assign rx.word_valid = vld_q;
endmodule

// ---- verilog/dacp_top.sv ----
// Top: conversion control, serial clock divider and dual-line capture
// Contract
// - Receive port uses external bit clock and frame sync and is enabled.
// - Frame sync is active low, one per received word.
// - Data sampled on rising serial clock edge, assembled MSB first.
// - Secondary channel captures converter B alongside converter A.
// - Word length 1111 gives 16 bits, 1101 gives 14; upper bits zero.
// - Power-down uses word length 1001, an 8-clock burst.
// - Control module drives chip select; data comes only via receive port.
// - Serial clock up to 32 MHz; dual conversion in 437.5 ns.
module dacp_top
  import dacp_pkg::*;
#(
  parameter int DIV_WIDTH = DIV_W
)
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_start,
  input  wire logic        i_power_down,
  input  wire logic        i_mode_14bit,
  input  wire logic [15:0] i_sclk_half_div,
  input  wire logic        i_receive_serial_clock,
  input  wire logic        i_receive_frame_sync_n,
  input  wire logic        i_converter_a_data_out,
  input  wire logic        i_converter_b_data_out,
  output logic             o_converter_cs_n,
  output logic             o_converter_serial_clock,
  output logic             o_busy,
  output logic [15:0]      o_result_a,
  output logic [15:0]      o_result_b,
  output logic             o_result_valid
);
  // ****************************************************
  // Elaboration checks
  // ****************************************************
  // Divider counter and ceiling guard assume these bounds
  if (DIV_WIDTH < 2 || DIV_WIDTH > 16) begin : g_div_width_check
    $error("DIV_WIDTH out of range");
  end
  // Shift registers are sized for the longest word only
  if (WORD_W != 16) begin : g_word_width_check
    $error("WORD_W must be 16");
  end
  // Power-down burst must stay shorter than any data word
  if (PD_BURST >= 5'h0e) begin : g_pd_burst_check
    $error("PD_BURST too long");
  end

  // ****************************************************
  // Helpers
  // ****************************************************
  // Serial clocks per frame for a word length setting
  function automatic logic [4:0] frame_bits(input logic [3:0] len);
    if (len == WLEN_PD) begin
      return PD_BURST;
    end
    return 5'(len) + 5'd1;
  endfunction

  // ****************************************************
  // Pin synchronisers
  // ****************************************************
  logic [1:0] sclk_s_q;
  logic [1:0] fs_s_q;
  logic [1:0] da_s_q;
  logic [1:0] db_s_q;
  logic       sclk_prev_q;

  // Link clock idles high; reset to that level so no false edge follows
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sclk_s_q    <= 2'b11;
      fs_s_q      <= 2'b11;
      da_s_q      <= 2'b00;
      db_s_q      <= 2'b00;
      sclk_prev_q <= 1'b1;
    end else begin
      sclk_s_q    <= {sclk_s_q[0], i_receive_serial_clock};
      fs_s_q      <= {fs_s_q[0], i_receive_frame_sync_n};
      da_s_q      <= {da_s_q[0], i_converter_a_data_out};
      db_s_q      <= {db_s_q[0], i_converter_b_data_out};
      sclk_prev_q <= sclk_s_q[1];
    end
  end

  // Rising edge found on the synchronised external clock
  wire logic sclk_rise = sclk_s_q[1] && !sclk_prev_q;

  // ****************************************************
  // Conversion control
  // ****************************************************
  dacp_rx_if rx ();

  dacp_state_t st_q;
  logic [15:0] div_cnt_q;
  logic [4:0]  edge_cnt_q;
  logic        cs_n_q;
  logic        sclk_q;
  logic [3:0]  len_q;

  // Power-down wins; 14-bit else 16-bit
  wire logic [3:0] len_sel = i_power_down ? WLEN_PD : (i_mode_14bit ? WLEN_14 : WLEN_16);
  wire logic [4:0] burst   = frame_bits(len_q);
  // Divider floor keeps the serial clock within its 32 MHz ceiling
  wire logic [15:0] half   = (i_sclk_half_div < DIV_RESET + 16'h0001) ? 16'h0002
                                                                       : i_sclk_half_div;
  wire logic        tick   = (div_cnt_q >= half - 16'h0001);
  wire logic        st_idle  = (st_q == ST_IDLE);
  // Power-down frames never reach the result registers
  wire logic        pd_frame = (len_q == WLEN_PD);
  wire logic        take_res = rx.word_valid && !pd_frame;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q       <= ST_IDLE;
      div_cnt_q  <= 16'h0000;
      edge_cnt_q <= 5'h00;
      cs_n_q     <= 1'b1;
      sclk_q     <= 1'b1;
      len_q      <= WLEN_16;
    end else begin
      div_cnt_q <= tick ? 16'h0000 : div_cnt_q + 16'h0001;
      case (st_q)
        ST_IDLE: begin
          sclk_q <= 1'b1;
          if (i_start) begin
            // Chip select fall starts sampling
            len_q     <= len_sel;
            cs_n_q    <= 1'b0;
            div_cnt_q <= 16'h0000;
            st_q      <= ST_ASSERT;
          end
        end
        ST_ASSERT: begin
          if (tick) begin
            edge_cnt_q <= 5'h00;
            sclk_q     <= 1'b0;
            st_q       <= ST_BURST;
          end
        end
        ST_BURST: begin
          // Conversion paced by the serial clock count
          if (tick) begin
            sclk_q <= !sclk_q;
            if (!sclk_q) begin
              edge_cnt_q <= edge_cnt_q + 5'd1;
              if (edge_cnt_q == burst - 5'd1) begin
                st_q <= ST_GAP;
              end
            end
          end
        end
        ST_GAP: begin
          // Select held one half period past the last rising edge
          if (tick) begin
            cs_n_q <= 1'b1;
            sclk_q <= 1'b1;
            st_q   <= ST_IDLE;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Port always enabled for reception
  assign rx.enable   = 1'b1;
  assign rx.word_len = len_q;

  // ****************************************************
  // Receive port and result registers
  // ****************************************************
  // Receiver sees the link only through the synchronisers
  dacp_serial_rx u_rx (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_sclk_rise (sclk_rise),
    .i_fs_n      (fs_s_q[1]),
    .i_data_a    (da_s_q[1]),
    .i_data_b    (db_s_q[1]),
    .rx          (rx)
  );

  logic [15:0] res_a_q;
  logic [15:0] res_b_q;
  logic        res_v_q;
  logic        busy_q;

  // Results only from the receive port
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      res_a_q <= 16'h0000;
      res_b_q <= 16'h0000;
      res_v_q <= 1'b0;
      busy_q  <= 1'b0;
    end else begin
      res_v_q <= take_res;
      // Busy rises with the accepted start; starts are refused only while the state is not ST_IDLE
      busy_q  <= !st_idle || i_start;
      if (take_res) begin
        res_a_q <= rx.word_a;
        res_b_q <= rx.word_b;
      end
    end
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  assign o_converter_cs_n         = cs_n_q;
  assign o_converter_serial_clock = sclk_q;
  assign o_busy                   = busy_q;
  assign o_result_a               = res_a_q;
  assign o_result_b               = res_b_q;
  assign o_result_valid           = res_v_q;
endmodule

// ---- tb/dacp_conv_model.sv ----
// Behavioural model of the dual converter driving both serial data lines
module dacp_conv_model (
  input  wire logic        i_cs_n,
  input  wire logic        i_sclk,
  input  wire logic [15:0] i_word_a,
  input  wire logic [15:0] i_word_b,
  output logic             o_da,
  output logic             o_db
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] wa_q = 16'h0;
  logic [15:0] wb_q = 16'h0;
  int          rise_q = 0;
  initial o_da = 1'b0;
  initial o_db = 1'b0;
  // Sample taken at select fall, words passed on in either coding
  always @(negedge i_cs_n) begin
    wa_q = i_word_a;
    wb_q = i_word_b;
    rise_q = 0;
    o_da = wa_q[15];
    o_db = wb_q[15];
  end
  always @(posedge i_sclk) if (!i_cs_n) rise_q++;
  // Shift on falling clock so bits are steady at the rising edge
  always @(negedge i_sclk) if (!i_cs_n && rise_q < 16) begin
    o_da = wa_q[15-rise_q];
    o_db = wb_q[15-rise_q];
  end
  // Released lines show no stale bit
  always @(posedge i_cs_n) begin
    o_da = ~o_da;
    o_db = ~o_db;
  end
endmodule

// ---- tb/dacp_top_sva.sv ----
// Port checker for the dual converter capture block
module dacp_top_sva (
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic        i_start,
  input wire logic        i_power_down,
  input wire logic        i_mode_14bit,
  input wire logic        o_converter_cs_n,
  input wire logic        o_converter_serial_clock,
  input wire logic        o_busy,
  input wire logic [15:0] o_result_a,
  input wire logic [15:0] o_result_b,
  input wire logic        o_result_valid
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_start_drops_cs: assert property (
    !o_busy && i_start |=> o_busy && !o_converter_cs_n)
    else $error("start did not begin a frame");
  a_sclk_idle_high: assert property (
    o_converter_cs_n |-> o_converter_serial_clock)
    else $error("serial clock low outside frame");
  a_sclk_in_frame: assert property (
    $fell(o_converter_serial_clock) |-> !o_converter_cs_n)
    else $error("serial clock fell without select");
  a_cs_min_low: assert property (
    $fell(o_converter_cs_n) |-> ##1 (!o_converter_cs_n) [*8])
    else $error("select frame too short");
  a_busy_cover_cs: assert property (!o_converter_cs_n |-> o_busy)
    else $error("select low while idle");
  a_valid_one_cycle: assert property (o_result_valid |=> !o_result_valid)
    else $error("valid longer than one cycle");
  a_result_hold: assert property (
    !o_result_valid |-> $stable(o_result_a) && $stable(o_result_b))
    else $error("results changed without valid");
  a_upper_zero: assert property (
    o_result_valid && i_mode_14bit |-> !(|o_result_a[15:14]) && !(|o_result_b[15:14]))
    else $error("upper bits not zero in short word");
  a_pd_no_valid: assert property (i_power_down && o_busy |-> !o_result_valid)
    else $error("power-down frame gave results");
  c_full: cover property (o_result_valid && !i_mode_14bit);
  c_short: cover property (o_result_valid && i_mode_14bit);
  c_pd: cover property ($fell(o_busy) && i_power_down);
endmodule
bind dacp_top dacp_top_sva u_sva (.i_clk, .i_rst, .i_start, .i_power_down, .i_mode_14bit,
  .o_converter_cs_n, .o_converter_serial_clock, .o_busy, .o_result_a, .o_result_b,
  .o_result_valid);

// ---- tb/test_dual_adc_serial_capture.sv ----
// Self-checking bench for the dual converter capture block
module test_dual_adc_serial_capture;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 0, rst = 1, start = 0, pd = 0, m14 = 0;
  logic [15:0] wa = 16'h0, wb = 16'h0, div = 16'h0008;
  logic        cs_n, sclk, busy, vld, da, db;
  logic [15:0] ra, rb;
  int          failures = 0, compares = 0, cyc = 0, r, v, lo;
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      end_of_test();
    end
  end
  // Half period 8 cycles gives the 160 ns link clock
  dacp_top dut (.i_clk(clk), .i_rst(rst), .i_start(start), .i_power_down(pd), .i_mode_14bit(m14),
    .i_sclk_half_div(div), .i_receive_serial_clock(sclk), .i_receive_frame_sync_n(cs_n),
    .i_converter_a_data_out(da), .i_converter_b_data_out(db), .o_converter_cs_n(cs_n),
    .o_converter_serial_clock(sclk), .o_busy(busy), .o_result_a(ra), .o_result_b(rb),
    .o_result_valid(vld));
  dacp_conv_model conv (.i_cs_n(cs_n), .i_sclk(sclk), .i_word_a(wa), .i_word_b(wb),
    .o_da(da), .o_db(db));
  task chk(input string n, input logic [15:0] e, input logic [15:0] s);
    compares++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task frame(input logic p, input logic m);
    logic prev;
    int   idle;
    @(posedge clk); #1 pd = p; m14 = m; start = 1;
    @(posedge clk); #1 start = 0; r = 0; v = 0; prev = 1;
    lo   = cs_n ? 0 : 1;
    idle = 0;
    // Results may land a few cycles after busy falls at fast link rates
    repeat (3000) begin
      @(posedge clk); #1
      if (sclk && !prev && !cs_n) r++;
      prev = sclk;
      if (vld) v++;
      if (!cs_n) lo++;
      idle = (!busy && !vld) ? idle + 1 : 0;
      if (idle == 4) break;
    end
    chk("busy_end", 16'h0000, {15'h0000, busy});
  endtask
  task t_reset;
    chk("cs_n", 1, cs_n);
    chk("sclk", 1, sclk);
    chk("busy", 0, busy);
    chk("result_a", 0, ra);
    chk("valid", 0, vld);
  endtask
  task t_word16;
    wa = 16'ha5c3; wb = 16'h3c5a;
    frame(0, 0);
    chk("rises", 16, r[15:0]);
    chk("valids", 1, v[15:0]);
    chk("cs_low", 16'h0108, lo[15:0]);
    chk("result_a", wa, ra);
    chk("result_b", wb, rb);
  endtask
  task t_word14;
    wa = 16'hf00f; wb = 16'h8001;
    frame(0, 1);
    chk("rises", 14, r[15:0]);
    chk("result_a", {2'b00, wa[15:2]}, ra);
    chk("result_b", {2'b00, wb[15:2]}, rb);
  endtask
  task t_power_down;
    wa = 16'h0ff0;
    frame(1, 0);
    chk("rises", 8, r[15:0]);
    chk("valids", 0, v[15:0]);
    chk("result_a", 16'h3c03, ra);
    chk("result_b", 16'h2000, rb);
  endtask
  task t_back_to_back;
    wa = 16'h1234; wb = 16'hfedc;
    frame(0, 0);
    chk("result_a", 16'h1234, ra);
    chk("result_b", 16'hfedc, rb);
    wa = 16'h8000; wb = 16'h0001;
    frame(0, 0);
    chk("result_a", 16'h8000, ra);
    chk("result_b", 16'h0001, rb);
  endtask
  // Divider below the floor must still give a 4-cycle serial clock
  task t_fast_floor;
    div = 16'h0001;
    wa  = 16'h5a69; wb = 16'h96a5;
    frame(0, 0);
    chk("cs_low", 16'h0042, lo[15:0]);
    chk("result_a", 16'h5a69, ra);
    chk("result_b", 16'h96a5, rb);
    div = 16'h0008;
  endtask
  task end_of_test;
    if (failures == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    #1 rst = 0;
    t_reset();
    t_word16();
    t_word14();
    t_power_down();
    t_back_to_back();
    t_fast_floor();
    end_of_test();
  end
endmodule
